/* logic/fwsr_pkg.sv */
// constants, encodings and carriers for the flash write-status host controller
// assumes a single 250 MHz clock domain and a 16-bit asynchronous NOR flash bus
package fwsr_pkg;
  localparam int unsigned CLK_MHZ   = 250;
  localparam int unsigned T_ACC_NS  = 70;
  localparam int unsigned T_WP_NS   = 35;
  localparam int unsigned T_REC_NS  = 20;
  localparam int unsigned ACC_CYC   = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WP_CYC    = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned REC_CYC   = (T_REC_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SYNC_LAT  = 2;
  localparam int unsigned CNT_W     = 8;
  localparam int unsigned AW        = 22;
  localparam int unsigned DW        = 16;

  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA  = 8'h10;

  localparam int unsigned CTRL_OP_LSB   = 0;
  localparam int unsigned CTRL_OP_W     = 3;
  localparam int unsigned CTRL_SKIP_BIT = 4;

  localparam int unsigned BIT_POLL = 7;
  localparam int unsigned BIT_TGL1 = 6;
  localparam int unsigned BIT_TLIM = 5;
  localparam int unsigned BIT_EWIN = 3;
  localparam int unsigned BIT_TGL2 = 2;

  typedef enum logic [2:0] {
    OP_NONE      = 3'h0,
    OP_READ      = 3'h1,
    OP_WRITE     = 3'h2,
    OP_POLL      = 3'h3,
    OP_ERASE_ADD = 3'h4
  } fwsr_op_type;

  // status register, bit 7 first
  typedef struct packed {
    logic ready;
    logic ewin;
    logic tgl2_seen;
    logic suspended;
    logic rejected;
    logic fail;
    logic done;
    logic busy;
  } fwsr_stat_type;
  localparam fwsr_stat_type STAT_RST = 8'h00;

  typedef struct packed {
    logic          we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } fwsr_req_type;

  typedef struct packed {
    logic          ce_b;
    logic          oe_b;
    logic          we_b;
    logic          dq_oe_b;
    logic [AW-1:0] addr;
    logic [DW-1:0] dq_o;
  } fwsr_pin_type;
  localparam fwsr_pin_type PIN_IDLE = {4'hf, {AW{1'b0}}, {DW{1'b0}}};
endpackage

/* logic/fwsr_sync.sv */
// two-flop synchroniser for flash pins
// assumes inputs are asynchronous to MCLK; the first stage feeds only the second
`timescale 1ns/10ps
`default_nettype none
module fwsr_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         en,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      dout   <= '0;
    end else if (en) begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule // fwsr_sync
`default_nettype wire

/* logic/fwsr_cyc.sv */
// one asynchronous flash bus cycle (read or write) per start pulse
// assumes dq_sync is the flash data bus after a two-flop synchroniser
`timescale 1ns/10ps
`default_nettype none
module fwsr_cyc
  import fwsr_pkg::*;
#(
  parameter int unsigned ACC = ACC_CYC,
  parameter int unsigned WP  = WP_CYC,
  parameter int unsigned REC = REC_CYC
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         en,
  input  wire logic         start,
  input  wire fwsr_req_type req,
  input  wire logic [DW-1:0] dq_sync,
  output var  fwsr_pin_type pins,
  output var  logic [DW-1:0] rdata,
  output var  logic         done
);
  typedef enum logic [1:0] {
    CY_IDLE = 2'h0,
    CY_ACT  = 2'h1,
    CY_REC  = 2'h2
  } fwsr_cy_type;

  fwsr_cy_type      st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  fwsr_pin_type     pins_d;
  logic [DW-1:0]    rdata_d;
  logic             done_d;

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    pins_d  = pins;
    rdata_d = rdata;
    done_d  = 1'b0;
    case (st_q)
      CY_IDLE: begin
        if (start) begin
          pins_d.ce_b    = 1'b0;
          pins_d.oe_b    = req.we;
          pins_d.we_b    = !req.we;
          pins_d.dq_oe_b = !req.we;
          pins_d.addr    = req.addr;
          pins_d.dq_o    = req.wdata;
          // reads stay low long enough for the synchroniser to catch the data
          cnt_d = req.we ? CNT_W'(WP - 1) : CNT_W'(ACC + SYNC_LAT - 1);
          st_d  = CY_ACT;
        end
      end
      CY_ACT: begin
        cnt_d = cnt_q - CNT_W'(1);
        if (cnt_q == '0) begin
          if (pins.we_b) begin
            rdata_d = dq_sync;
          end
          pins_d.ce_b = 1'b1;
          pins_d.oe_b = 1'b1;
          pins_d.we_b = 1'b1;
          cnt_d       = CNT_W'(REC - 1);
          st_d        = CY_REC;
        end
      end
      CY_REC: begin
        cnt_d = cnt_q - CNT_W'(1);
        if (cnt_q == '0) begin
          pins_d.dq_oe_b = 1'b1;
          done_d         = 1'b1;
          st_d           = CY_IDLE;
        end
      end
      default: begin
        pins_d = PIN_IDLE;
        st_d   = CY_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q  <= CY_IDLE;
      cnt_q <= '0;
      pins  <= PIN_IDLE;
      rdata <= '0;
      done  <= 1'b0;
    end else if (en) begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      pins  <= pins_d;
      rdata <= rdata_d;
      done  <= done_d;
    end
  end
endmodule // fwsr_cyc
`default_nettype wire

/* logic/fwsr_host.sv */
// host controller that drives a NOR flash and watches its write-operation status bits
// assumes a classic Wishbone master on the register side and the flash pins on the other
`timescale 1ns/10ps
`default_nettype none
module fwsr_host
  import fwsr_pkg::*;
#(
  parameter logic [DW-1:0] RESET_CMD = 16'h00f0
) (
  input  wire logic          MCLK,
  input  wire logic          RST_B,
  input  wire logic          EN,
  input  wire logic          WB_CYC_I,
  input  wire logic          WB_STB_I,
  input  wire logic          WB_WE_I,
  input  wire logic [7:0]    WB_ADR_I,
  input  wire logic [3:0]    WB_SEL_I,
  input  wire logic [31:0]   WB_DAT_I,
  output var  logic [31:0]   WB_DAT_O,
  output var  logic          WB_ACK_O,
  output var  logic          FL_CE_B,
  output var  logic          FL_OE_B,
  output var  logic          FL_WE_B,
  output var  logic [AW-1:0] FL_ADDR,
  output var  logic [DW-1:0] FL_DQ_O,
  output var  logic          FL_DQ_OE_B,
  input  wire logic [DW-1:0] FL_DQ_I,
  input  wire logic          FL_RYBY_I
);
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_SINGLE  = 4'h1,
    ST_P1      = 4'h2,
    ST_P2      = 4'h3,
    ST_P3      = 4'h4,
    ST_P4      = 4'h5,
    ST_RST     = 4'h6,
    ST_EW_PRE  = 4'h7,
    ST_EW_CMD  = 4'h8,
    ST_EW_POST = 4'h9
  } fwsr_st_type;

  // pins, synchronisers and the bus cycle engine
  logic [DW-1:0] dq_sync;
  logic          ryby_sync;
  fwsr_pin_type  pins;
  logic [DW-1:0] cyc_rdata;
  logic          cyc_done;
  fwsr_req_type  req_q, req_d;
  logic          go_q, go_d;

  fwsr_sync #(.W(DW + 1)) u_sync (
    .clk   (MCLK),
    .rst_b (RST_B),
    .en    (EN),
    .din   ({FL_RYBY_I, FL_DQ_I}),
    .dout  ({ryby_sync, dq_sync})
  );

  fwsr_cyc u_cyc (
    .clk     (MCLK),
    .rst_b   (RST_B),
    .en      (EN),
    .start   (go_q),
    .req     (req_q),
    .dq_sync (dq_sync),
    .pins    (pins),
    .rdata   (cyc_rdata),
    .done    (cyc_done)
  );

  assign FL_CE_B    = pins.ce_b;
  assign FL_OE_B    = pins.oe_b;
  assign FL_WE_B    = pins.we_b;
  assign FL_ADDR    = pins.addr;
  assign FL_DQ_O    = pins.dq_o;
  assign FL_DQ_OE_B = pins.dq_oe_b;

  // wishbone slave and software registers
  logic [AW-1:0]  addr_q, addr_d;
  logic [DW-1:0]  wdata_q, wdata_d;
  logic [DW-1:0]  rdata_q, rdata_d;
  logic           skip_q, skip_d;
  logic           ack_d;
  logic [31:0]    dat_d;
  logic [31:0]    sel_mask;
  logic           wr_acc;
  logic           start_w;
  fwsr_op_type    op_w;
  fwsr_stat_type  stat_q, stat_d;
  fwsr_st_type    st_q, st_d;
  logic [DW-1:0]  s1_q, s1_d;

  always_comb begin
    sel_mask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    wr_acc   = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O;
    ack_d    = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    start_w  = wr_acc && (WB_ADR_I == REG_CTRL) && WB_SEL_I[0];
    op_w     = fwsr_op_type'(WB_DAT_I[CTRL_OP_LSB +: CTRL_OP_W]);
    addr_d   = addr_q;
    wdata_d  = wdata_q;
    if (wr_acc && (WB_ADR_I == REG_ADDR)) begin
      addr_d = AW'(({10'h000, addr_q} & ~sel_mask) | (WB_DAT_I & sel_mask));
    end
    if (wr_acc && (WB_ADR_I == REG_WDATA)) begin
      wdata_d = DW'(({16'h0000, wdata_q} & ~sel_mask) | (WB_DAT_I & sel_mask));
    end
    case (WB_ADR_I)
      REG_CTRL:   dat_d = {27'h0000000, skip_q, 1'b0, 3'h0};
      REG_ADDR:   dat_d = {10'h000, addr_q};
      REG_WDATA:  dat_d = {16'h0000, wdata_q};
      REG_STATUS: dat_d = {24'h000000, stat_q};
      REG_RDATA:  dat_d = {16'h0000, rdata_q};
      default:    dat_d = 32'h00000000;
    endcase
    if (!ack_d) begin
      dat_d = WB_DAT_O;
    end
  end

  // operation sequencer
  always_comb begin
    st_d    = st_q;
    go_d    = 1'b0;
    req_d   = req_q;
    s1_d    = s1_q;
    rdata_d = rdata_q;
    skip_d  = skip_q;
    stat_d  = stat_q;
    stat_d.ready = ryby_sync;
    // status reads always use the software address of the busy location
    req_d.addr = addr_q;
    case (st_q)
      ST_IDLE: begin
        // a start while busy cannot happen here; it is simply ignored elsewhere
        if (start_w && (op_w != OP_NONE)) begin
          skip_d           = WB_DAT_I[CTRL_SKIP_BIT];
          stat_d.done      = 1'b0;
          stat_d.fail      = 1'b0;
          stat_d.rejected  = 1'b0;
          stat_d.suspended = 1'b0;
          stat_d.tgl2_seen = 1'b0;
          stat_d.busy      = 1'b1;
          req_d.wdata      = wdata_q;
          go_d             = 1'b1;
          case (op_w)
            OP_READ: begin
              req_d.we = 1'b0;
              st_d     = ST_SINGLE;
            end
            OP_WRITE: begin
              req_d.we = 1'b1;
              st_d     = ST_SINGLE;
            end
            OP_POLL: begin
              req_d.we = 1'b0;
              st_d     = ST_P1;
            end
            OP_ERASE_ADD: begin
              // with tight spacing guaranteed by software the window check is skipped
              req_d.we = WB_DAT_I[CTRL_SKIP_BIT];
              st_d     = WB_DAT_I[CTRL_SKIP_BIT] ? ST_EW_CMD : ST_EW_PRE;
            end
            default: begin
              go_d = 1'b0;
              st_d = ST_IDLE;
            end
          endcase
        end
      end
      ST_SINGLE: begin
        if (cyc_done) begin
          if (!req_q.we) begin
            rdata_d = cyc_rdata;
          end
          stat_d.done = 1'b1;
          st_d        = ST_IDLE;
        end
      end
      ST_P1, ST_P3: begin
        if (cyc_done) begin
          s1_d = cyc_rdata;
          go_d = 1'b1;
          st_d = (st_q == ST_P1) ? ST_P2 : ST_P4;
        end
      end
      ST_P2: begin
        if (cyc_done) begin
          rdata_d = cyc_rdata;
          if (cyc_rdata[BIT_TGL2] != s1_q[BIT_TGL2]) begin
            stat_d.tgl2_seen = 1'b1;
          end
          if (cyc_rdata[BIT_TGL1] == s1_q[BIT_TGL1]) begin
            // steady toggle one with a moving toggle two marks a suspended sector
            stat_d.suspended = (cyc_rdata[BIT_TGL2] != s1_q[BIT_TGL2]);
            stat_d.done      = 1'b1;
            st_d             = ST_IDLE;
          end else if (cyc_rdata[BIT_TLIM]) begin
            // toggle may stop just as the limit flag rises: check twice more
            go_d = 1'b1;
            st_d = ST_P3;
          end else begin
            s1_d = cyc_rdata;
            go_d = 1'b1;
          end
        end
      end
      ST_P4: begin
        if (cyc_done) begin
          rdata_d = cyc_rdata;
          if (cyc_rdata[BIT_TGL1] == s1_q[BIT_TGL1]) begin
            stat_d.done = 1'b1;
            st_d        = ST_IDLE;
          end else begin
            req_d.we    = 1'b1;
            req_d.wdata = RESET_CMD;
            go_d        = 1'b1;
            st_d        = ST_RST;
          end
        end
      end
      ST_RST: begin
        if (cyc_done) begin
          stat_d.fail = 1'b1;
          stat_d.done = 1'b1;
          st_d        = ST_IDLE;
        end
      end
      ST_EW_PRE: begin
        if (cyc_done) begin
          stat_d.ewin = cyc_rdata[BIT_EWIN];
          if (cyc_rdata[BIT_EWIN]) begin
            // erase already running: the device would ignore the command
            stat_d.rejected = 1'b1;
            stat_d.done     = 1'b1;
            st_d            = ST_IDLE;
          end else begin
            req_d.we = 1'b1;
            go_d     = 1'b1;
            st_d     = ST_EW_CMD;
          end
        end
      end
      ST_EW_CMD: begin
        if (cyc_done) begin
          if (skip_q) begin
            stat_d.done = 1'b1;
            st_d        = ST_IDLE;
          end else begin
            req_d.we = 1'b0;
            go_d     = 1'b1;
            st_d     = ST_EW_POST;
          end
        end
      end
      ST_EW_POST: begin
        if (cyc_done) begin
          stat_d.ewin     = cyc_rdata[BIT_EWIN];
          stat_d.rejected = cyc_rdata[BIT_EWIN];
          stat_d.done     = 1'b1;
          st_d            = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    // busy falls on the same edge at which done rises
    stat_d.busy = (st_d != ST_IDLE);
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
      addr_q   <= '0;
      wdata_q  <= '0;
      rdata_q  <= '0;
      skip_q   <= 1'b0;
      stat_q   <= STAT_RST;
      st_q     <= ST_IDLE;
      s1_q     <= '0;
      go_q     <= 1'b0;
      req_q    <= '0;
    end else if (EN) begin
      WB_ACK_O <= ack_d;
      WB_DAT_O <= dat_d;
      addr_q   <= addr_d;
      wdata_q  <= wdata_d;
      rdata_q  <= rdata_d;
      skip_q   <= skip_d;
      stat_q   <= stat_d;
      st_q     <= st_d;
      s1_q     <= s1_d;
      go_q     <= go_d;
      req_q    <= req_d;
    end
  end

  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  reset_write_a: assert property ((st_q == ST_P4) && cyc_done && EN && (cyc_rdata[BIT_TGL1] != s1_q[BIT_TGL1])
    |=> ##1 (!FL_WE_B && (FL_DQ_O == RESET_CMD)))
    else $error("reset command not written after overrun");
  fail_after_reset_a: assert property ($rose(stat_q.fail) |-> $past(st_q) == ST_RST)
    else $error("fail flag without reset write");
  skip_no_read_a: assert property ((st_q == ST_EW_CMD) && skip_q |-> FL_OE_B)
    else $error("window read issued in skip mode");
  recheck_read_a: assert property ((st_q == ST_EW_CMD) && !skip_q && cyc_done && EN
    |=> ##1 (!FL_OE_B && !FL_CE_B))
    else $error("no window read after extra sector command");
  reject_cause_a: assert property ($rose(stat_q.rejected)
    |-> ($past(st_q) == ST_EW_POST) || ($past(st_q) == ST_EW_PRE))
    else $error("reject flag without window check");
  status_addr_a: assert property (!FL_OE_B && (st_q inside {ST_P1, ST_P2, ST_P3, ST_P4}) |-> FL_ADDR == addr_q)
    else $error("status read off the busy address");
  strobe_excl_a: assert property (!(!FL_OE_B && !FL_WE_B))
    else $error("read and write strobes low together");
  ack_pulse_a: assert property (WB_ACK_O && EN |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");

  poll_ok_c: cover property ((st_q == ST_P2) && cyc_done && (cyc_rdata[BIT_TGL1] == s1_q[BIT_TGL1]));
  poll_fail_c: cover property ($rose(stat_q.fail));
  ew_reject_c: cover property ($rose(stat_q.rejected));
  suspend_c: cover property ($rose(stat_q.suspended));
endmodule // fwsr_host
`default_nettype wire

/* verif/fwsr_flash_model.sv */
// behavioural flash with two banks that answers the host's asynchronous bus with write-operation status
// assumes the bench resolves the data bus and pulls ready/busy up; set_state forces the running algorithm
`timescale 1ns/10ps
`default_nettype none
module fwsr_flash_model
  import fwsr_pkg::*;
#(
  parameter int unsigned TOUT_NS    = 2000,
  parameter int unsigned DONE_READS = 3,
  parameter logic        PROG_BIT7  = 1'b1
) (
  input  wire logic          ce_b,
  input  wire logic          oe_b,
  input  wire logic          we_b,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] dq_in,
  input  wire logic [2:0]    set_state,
  input  wire logic          set_stb,
  output var  logic [DW-1:0] dq_out,
  output var  logic          ryby_low,
  output var  logic [2:0]    state_o,
  output var  logic [7:0]    erase_cnt
);
  localparam logic [2:0] S_READ  = 3'h0;
  localparam logic [2:0] S_PROG  = 3'h1;
  localparam logic [2:0] S_ERASE = 3'h2;
  localparam logic [2:0] S_SUSP  = 3'h3;
  localparam logic [2:0] S_FAIL  = 3'h4;
  logic [2:0]    st      = 3'h0;
  logic          tgl1    = 1'b0;
  logic          tgl2    = 1'b0;
  int unsigned   nrd     = 0;
  realtime       win_end = 0.0;
  logic [DW-1:0] rdq     = 16'h0000;
  logic [DW-1:0] last    = 16'h0000;
  wire logic     rd_b    = ce_b | oe_b;
  wire logic     wr_b    = ce_b | we_b;

  function automatic logic [DW-1:0] arr(input logic [AW-1:0] a);
    return a[15:0] ^ 16'h5a5a;
  endfunction

  initial begin
    erase_cnt = 8'h00;
  end
  assign state_o  = st;
  assign ryby_low = (st == S_PROG) || (st == S_ERASE) || (st == S_FAIL);
  // a released bus shows the inverse of the last word
  assign dq_out   = rd_b ? ~last : rdq;

  always @(posedge set_stb) begin
    st = set_state;
    nrd = 0;
  end
  always @(posedge rd_b) begin
    last = rdq;
  end
  // bank 0 runs the algorithm; bank 1 always gives array data
  always @(negedge rd_b) begin
    logic closed;
    // let the address settle behind the falling strobe
    #1;
    closed = ($realtime >= win_end);
    if (st == S_READ || addr[AW-1]) begin
      rdq = arr(addr);
    end else begin
      case (st)
        S_ERASE: rdq = {8'h00, 1'b0, tgl1, 2'b00, closed, tgl2, 2'b00};
        S_SUSP:  rdq = {8'h00, 1'b1, tgl1, 3'b000, tgl2, 2'b00};
        default: rdq = {8'h00, ~PROG_BIT7, tgl1, st == S_FAIL, 5'h00};
      endcase
      if (st != S_SUSP) tgl1 = ~tgl1;
      if (st == S_ERASE || st == S_SUSP) tgl2 = ~tgl2;
      if (st != S_ERASE || closed) nrd++;
      if ((st == S_PROG || st == S_ERASE) && nrd >= DONE_READS) st = S_READ;
    end
  end
  always @(posedge wr_b) begin
    if (dq_in == 16'h00f0 && st != S_ERASE) begin
      st = S_READ;
    end else if (dq_in == 16'h0030 && (st == S_READ || (st == S_ERASE && $realtime < win_end))) begin
      st = S_ERASE;
      win_end = $realtime + TOUT_NS;
      nrd = 0;
      erase_cnt = erase_cnt + 8'h01;
    end else if (dq_in == 16'h00b0 && st == S_ERASE) begin
      st = S_SUSP;
    end
  end
endmodule // fwsr_flash_model
`default_nettype wire

/* verif/testbench.sv */
// self-checking bench for the flash write-status host controller
// assumes fwsr_flash_model on the flash pins; Wishbone tasks act as the software side
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import fwsr_pkg::*;
  logic          mclk      = 1'b0;
  logic          rst_b     = 1'b0;
  logic          wb_cyc    = 1'b0;
  logic          wb_stb    = 1'b0;
  logic          wb_we     = 1'b0;
  logic [7:0]    wb_adr    = 8'h00;
  logic [31:0]   wb_wdat   = 32'h0000_0000;
  logic [31:0]   wb_rdat;
  logic          wb_ack;
  logic          ce_b;
  logic          oe_b;
  logic          we_b;
  logic          dq_oe_b;
  logic          ryby_low;
  logic [AW-1:0] fl_addr;
  logic [DW-1:0] dq_o;
  logic [DW-1:0] dq_m;
  logic [DW-1:0] dq_bus;
  logic [2:0]    set_state = 3'h0;
  logic          set_stb   = 1'b0;
  logic [2:0]    m_state;
  logic [7:0]    erase_cnt;
  logic [31:0]   rd_q;
  int            err_total = 0;
  int            checks    = 0;

  assign dq_bus = dq_oe_b ? dq_m : dq_o;
  always #2 mclk = ~mclk;

  fwsr_host dut (
    .MCLK(mclk), .RST_B(rst_b), .EN(1'b1), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb), .WB_WE_I(wb_we),
    .WB_ADR_I(wb_adr), .WB_SEL_I(4'hf), .WB_DAT_I(wb_wdat), .WB_DAT_O(wb_rdat), .WB_ACK_O(wb_ack),
    .FL_CE_B(ce_b), .FL_OE_B(oe_b), .FL_WE_B(we_b), .FL_ADDR(fl_addr), .FL_DQ_O(dq_o),
    .FL_DQ_OE_B(dq_oe_b), .FL_DQ_I(dq_bus), .FL_RYBY_I(~ryby_low)
  );
  fwsr_flash_model #(.TOUT_NS(2000), .DONE_READS(3)) flash (
    .ce_b(ce_b), .oe_b(oe_b), .we_b(we_b), .addr(fl_addr), .dq_in(dq_bus), .set_state(set_state),
    .set_stb(set_stb), .dq_out(dq_m), .ryby_low(ryby_low), .state_o(m_state), .erase_cnt(erase_cnt)
  );

  function automatic logic [31:0] exp_word(input logic [AW-1:0] a);
    return {16'h0000, a[15:0] ^ 16'h5a5a};
  endfunction

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask

  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= a;
    wb_wdat <= d;
    @(posedge mclk);
    while (wb_ack !== 1'b1) begin
      @(posedge mclk);
    end
    rd_q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_xfer(1'b1, a, d);
  endtask

  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
    wb_xfer(1'b0, a, 32'h0000_0000);
    chk(name, exp & mask, rd_q & mask);
  endtask

  // starts one operation and polls until busy clears
  task automatic run_op(input logic [2:0] op, input logic skip);
    int n;
    n = 0;
    wr(REG_CTRL, {27'h0, skip, 1'b0, op});
    rd_q = 32'h0000_0001;
    while (rd_q[0] !== 1'b0 && n < 1000) begin
      wb_xfer(1'b0, REG_STATUS, 32'h0000_0000);
      n++;
    end
    if (n >= 1000) begin
      $display("[FAIL] busy expected 0 seen 1");
      err_total++;
    end
  endtask

  task automatic set_model(input logic [2:0] st);
    @(posedge mclk);
    set_state <= st;
    set_stb   <= 1'b1;
    @(posedge mclk);
    set_stb   <= 1'b0;
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    rd("status reset", REG_STATUS, 32'h0, 32'h7f);
    rd("ctrl reset", REG_CTRL, 32'h0, 32'hffffffff);
    rd("unmapped", 8'h20, 32'h0, 32'hffffffff);
    wr(REG_ADDR, 32'h0000_0123);
    run_op(OP_READ, 1'b0);
    rd("array read", REG_RDATA, exp_word(22'h000123), 32'hffff);
    set_model(3'h1);
    wr(REG_ADDR, 32'h0020_0040);
    run_op(OP_READ, 1'b0);
    rd("idle bank read", REG_RDATA, exp_word(22'h200040), 32'hffff);
    rd("busy pin program", REG_STATUS, 32'h00, 32'h80);
    wr(REG_ADDR, 32'h0000_0040);
    run_op(OP_POLL, 1'b0);
    rd("program poll", REG_STATUS, 32'h02, 32'h27);
    set_model(3'h4);
    run_op(OP_POLL, 1'b0);
    rd("overrun poll", REG_STATUS, 32'h06, 32'h27);
    chk("reset command", 32'h0, {29'h0, m_state});
    set_model(3'h3);
    run_op(OP_POLL, 1'b0);
    rd("suspend poll", REG_STATUS, 32'hb2, 32'hb7);
    set_model(3'h0);
    wr(REG_ADDR, 32'h0000_0100);
    wr(REG_WDATA, 32'h0000_0030);
    run_op(OP_WRITE, 1'b0);
    chk("first sector", 32'h1, {24'h0, erase_cnt});
    repeat (350) @(posedge mclk);
    run_op(OP_ERASE_ADD, 1'b1);
    chk("skip sector", 32'h2, {24'h0, erase_cnt});
    rd("ctrl skip", REG_CTRL, 32'h10, 32'hffffffff);
    repeat (350) @(posedge mclk);
    run_op(OP_ERASE_ADD, 1'b0);
    rd("window open add", REG_STATUS, 32'h02, 32'hca);
    chk("open sector", 32'h3, {24'h0, erase_cnt});
    repeat (700) @(posedge mclk);
    run_op(OP_ERASE_ADD, 1'b0);
    rd("window closed add", REG_STATUS, 32'h4a, 32'hca);
    run_op(OP_WRITE, 1'b0);
    chk("late sector", 32'h3, {24'h0, erase_cnt});
    run_op(OP_POLL, 1'b0);
    rd("erase poll", REG_STATUS, 32'h22, 32'h27);
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
